//--- inc/obom_pkg.sv
// Shared constants and types for the output buffer occupancy monitor.
// Assumes a 25 MHz system clock and a register port with one-cycle read latency.
package obom_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25000000;   // System clock rate
  localparam int unsigned SAMPLE_PERIOD_US = 1000;      // Sample period, 1 ms
  localparam int unsigned SAMPLE_CYCLES   = (CLK_HZ / 1000000) * SAMPLE_PERIOD_US;
  localparam int unsigned HIST_DEPTH      = 1000;       // History entries

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;  // Enable, channel type
  localparam logic [11:0] OFS_NORM     = 12'h004;  // Normalization factor
  localparam logic [11:0] OFS_THRESH   = 12'h008;  // Alert threshold, write arms
  localparam logic [11:0] OFS_SMOOTH   = 12'h00c;  // Smoothing exponent N
  localparam logic [11:0] OFS_AVG      = 12'h010;  // Current average
  localparam logic [11:0] OFS_WPTR     = 12'h014;  // History write pointer
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;  // Sticky events, W1C
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;  // Event mask
  localparam logic [11:0] OFS_LAST     = 12'h020;  // Last sample
  localparam logic [11:0] OFS_HIST     = 12'h040;  // History window base, window must end below 12'hfff
  localparam logic [11:0] HIST_SPAN    = 12'hfa0;  // 1000 words

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT    = 0;   // Sampling enable
  localparam int unsigned CTRL_TYPE_LSB  = 1;   // Channel type field
  localparam int unsigned IRQ_ALERT_BIT  = 0;   // Average crossed threshold
  localparam int unsigned IRQ_SAMPLE_BIT = 1;   // A sample was stored
  localparam int unsigned IRQ_WRAP_BIT   = 2;   // History pointer wrapped
  localparam int unsigned IRQ_W          = 3;   // Event count
  localparam logic [23:0] NORM_RST       = 24'h000001;
  localparam logic [7:0]  THRESH_RST     = 8'hff;
  localparam logic [3:0]  SMOOTH_RST     = 4'h0;
  localparam logic [3:0]  SMOOTH_MAX     = 4'h8;   // N beyond 8 leaves no signal
  localparam logic [7:0]  FULL_CODE      = 8'hff;

  // Channel families that keep a history
  typedef enum logic [1:0] {
    OBOM_CH_DATA  = 2'h0,   // Cable data, multicarrier or single carrier
    OBOM_CH_VIDEO = 2'h1,   // Video transport stream
    OBOM_CH_NARROW = 2'h2   // Narrowband digital forward
  } obom_chan_type;

  // Monitor state, Gray coded
  typedef enum logic [1:0] {
    OBOM_IDLE    = 2'b00,   // Not armed
    OBOM_PRIME   = 2'b01,   // Armed, average cleared
    OBOM_WATCH   = 2'b11,   // Averaging, alert pending
    OBOM_FIRED   = 2'b10    // Alert sent, waits for rearm
  } obom_mon_type;

endpackage : obom_pkg

//--- design/obom_hist_mem.sv
// History memory: one write port, one read port, registered read data.
// Assumes write and read addresses are already in range.
`timescale 1ns/10ps
module obom_hist_mem #(
  parameter int unsigned DEPTH = 1000,            // Entries
  parameter int unsigned WIDTH = 8,               // Bits per entry
  parameter int unsigned AW    = 10               // Address width
) (
  input  wire logic             clk,              // System clock
  input  wire logic             wr_en,            // Write enable
  input  wire logic [AW-1:0]    wr_addr,          // Write address
  input  wire logic [WIDTH-1:0] wr_data,          // Write data
  input  wire logic             rd_en,            // Read enable
  input  wire logic [AW-1:0]    rd_addr,          // Read address
  output logic      [WIDTH-1:0] rd_data           // Registered read data
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [DEPTH];                // Sample array

  initial begin
    if (DEPTH > (1 << AW)) $error("obom_hist_mem: AW too small");
  end

  // Write and read share a clock but separate ports, so sampling never stalls
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule : obom_hist_mem

//--- design/obom_monitor.sv
// Output buffer occupancy monitor for one channel: sampling, history, average, alert.
// Assumes depths are synchronous, and the register master follows one-cycle strobes.
`timescale 1ns/10ps
module obom_monitor
  import obom_pkg::*;
#(
  parameter int unsigned NQ        = 4,                  // Output queues per channel
  parameter int unsigned QDW       = 20,                 // Bits of one queue depth
  parameter int unsigned TICK_CYC  = SAMPLE_CYCLES       // Cycles per sample tick
) (
  input  wire logic                 clk,                 // System clock
  input  wire logic                 rst_n,               // Async reset, active low
  input  wire logic [NQ*QDW-1:0]    queue_depth,         // Byte depth of each queue
  input  wire logic [11:0]          reg_addr,            // Register byte address
  input  wire logic [31:0]          reg_wdata,           // Register write data
  input  wire logic                 reg_wr,              // Write strobe
  input  wire logic                 reg_rd,              // Read strobe
  output logic      [31:0]          reg_rdata,           // Read data, cycle after strobe
  output logic                      alert_pulse,         // One-cycle alert to the core
  output logic                      irq                  // Level interrupt
);
  import obom_pkg::*;

  // ----------------------------------------------------------------
  // Parameters checks and local widths
  // ----------------------------------------------------------------
  localparam int unsigned SW = QDW + $clog2(NQ + 1);     // Sum width
  localparam int unsigned AW = 10;                       // History address width
  localparam int unsigned TW = $clog2(TICK_CYC + 1);     // Tick counter width

  initial begin
    if (NQ < 1) $error("obom_monitor: NQ must be at least one");
    if (SW > 32) $error("obom_monitor: depth sum wider than 32 bits");
    if (TICK_CYC < 3) $error("obom_monitor: TICK_CYC too small");
  end

  // Sum of all queue depths of the channel
  function automatic logic [SW-1:0] sum_depth(input logic [NQ*QDW-1:0] d);
    logic [SW-1:0] acc;
    acc = '0;
    for (int i = 0; i < NQ; i++) begin
      acc = acc + SW'(d[i*QDW +: QDW]);
    end
    return acc;
  endfunction : sum_depth

  // Divide by factor and clamp to the full-scale code
  function automatic logic [7:0] normalize(input logic [SW-1:0] b, input logic [23:0] f);
    logic [31:0] q;
    q = 32'(b) / ((f == 24'h0) ? 32'h1 : 32'(f));
    return (q > 32'(FULL_CODE)) ? FULL_CODE : q[7:0];
  endfunction : normalize

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                 en_r;          // Sampling enabled
  obom_chan_type        ctype_r;       // Channel family
  logic [23:0]          norm_r;        // Normalization factor
  logic [7:0]           thresh_r;      // Alert threshold
  logic [3:0]           smooth_r;      // Smoothing exponent N
  logic [IRQ_W-1:0]     stat_r;        // Sticky events
  logic [IRQ_W-1:0]     mask_r;        // Event mask
  logic [TW-1:0]        tick_cnt_r;    // Millisecond divider
  logic                 tick;          // One-cycle sample enable
  logic [AW-1:0]        wptr_r;        // Next history slot
  logic [7:0]           last_r;        // Last stored code
  logic [15:0]          avg_r;         // Average, 8.8 fixed point
  logic [15:0]          avg_nxt;       // Next average
  obom_mon_type         mon_r;         // Monitor state
  logic                 arm_wr;        // Threshold written
  logic [7:0]           cur_code;      // Code being sampled
  logic                 wrap;          // Pointer wraps this tick
  logic                 fire;          // Alert condition
  logic [IRQ_W-1:0]     ev;            // Events this cycle
  logic                 hist_hit;      // Read lands in history window
  logic                 hist_hit_r;    // Delayed history hit
  logic [AW-1:0]        hist_idx;      // History word index
  logic [7:0]           hist_q;        // Memory read data
  logic [31:0]          rdata_r;       // Register read data

  assign arm_wr   = reg_wr && (reg_addr == OFS_THRESH);
  assign cur_code = normalize(sum_depth(queue_depth), norm_r);
  assign wrap     = tick && en_r && (wptr_r == AW'(HIST_DEPTH - 1));

  // ----------------------------------------------------------------
  // Sample tick divider
  // ----------------------------------------------------------------
  // Free running so the tick spacing stays exact whatever software does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == TW'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r     <= 1'b0;
      ctype_r  <= OBOM_CH_DATA;
      norm_r   <= NORM_RST;
      thresh_r <= THRESH_RST;
      smooth_r <= SMOOTH_RST;
      mask_r   <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          en_r <= reg_wdata[CTRL_EN_BIT];
          // Unknown family codes fall back to data so history is always kept
          ctype_r <= (reg_wdata[CTRL_TYPE_LSB +: 2] == 2'h3) ? OBOM_CH_DATA
                                                          : obom_chan_type'(reg_wdata[CTRL_TYPE_LSB +: 2]);
        end
        OFS_NORM:     norm_r   <= reg_wdata[23:0];
        OFS_THRESH:   thresh_r <= reg_wdata[7:0];
        // Exponents past the cap would freeze the average, so clamp them
        OFS_SMOOTH:   smooth_r <= (reg_wdata[3:0] > SMOOTH_MAX) ? SMOOTH_MAX : reg_wdata[3:0];
        OFS_IRQ_MASK: mask_r   <= reg_wdata[IRQ_W-1:0];
        default: begin
          // Other offsets hold no configuration
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // History pointer and last sample
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      last_r <= 8'h00;
    end else if (tick && en_r) begin
      wptr_r <= wrap ? '0 : wptr_r + 1'b1;
      last_r <= cur_code;
    end
  end

  // ----------------------------------------------------------------
  // Moving average and one-shot alert
  // ----------------------------------------------------------------
  // A += (D - A) / 2^N in 8.8 fixed point keeps the fraction so small
  // alphas still converge instead of stalling on truncation
  always_comb begin
    logic signed [17:0] diff;
    diff    = $signed({2'b00, cur_code, 8'h00}) - $signed({2'b00, avg_r});
    avg_nxt = 16'($signed({2'b00, avg_r}) + (diff >>> smooth_r));
  end

  // Integer part of the average must be strictly above the threshold
  assign fire = (mon_r == OBOM_WATCH) && (avg_r[15:8] > thresh_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_r <= OBOM_IDLE;
      avg_r <= 16'h0000;
    end else if (arm_wr) begin
      mon_r <= OBOM_PRIME;
      avg_r <= 16'h0000;
    end else begin
      case (mon_r)
        OBOM_IDLE: begin
          mon_r <= OBOM_IDLE;
        end
        OBOM_PRIME: begin
          if (tick) begin
            avg_r <= avg_nxt;
            mon_r <= OBOM_WATCH;
          end
        end
        OBOM_WATCH: begin
          if (fire) begin
            mon_r <= OBOM_FIRED;
          end
          // Averaging never skips a tick, even when the alert leaves in the same cycle
          if (tick) begin
            avg_r <= avg_nxt;
          end
        end
        OBOM_FIRED: begin
          // Keep averaging for software visibility, alert stays latched
          if (tick) begin
            avg_r <= avg_nxt;
          end
        end
        default: begin
          mon_r <= OBOM_IDLE;
        end
      endcase
    end
  end

  assign alert_pulse = fire && !arm_wr;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    ev                 = '0;
    ev[IRQ_ALERT_BIT]  = alert_pulse;
    ev[IRQ_SAMPLE_BIT] = tick && en_r;
    ev[IRQ_WRAP_BIT]   = wrap;
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else if (reg_wr && (reg_addr == OFS_IRQ_STAT)) begin
      stat_r <= (stat_r & ~reg_wdata[IRQ_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // History memory and register read port
  // ----------------------------------------------------------------
  // End of window reckoned one bit wider so the sum cannot wrap
  assign hist_hit = (reg_addr >= OFS_HIST) && ({1'b0, reg_addr} < (13'(OFS_HIST) + 13'(HIST_SPAN)));
  assign hist_idx = AW'((reg_addr - OFS_HIST) >> 2);

  // Separate read port lets the core fetch history while sampling continues
  obom_hist_mem #(
    .DEPTH   (HIST_DEPTH),
    .WIDTH   (8),
    .AW      (AW)
  ) u_hist (
    .clk     (clk),
    .wr_en   (tick && en_r),
    .wr_addr (wptr_r),
    .wr_data (cur_code),
    .rd_en   (reg_rd && hist_hit),
    .rd_addr (hist_idx),
    .rd_data (hist_q)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r    <= 32'h0000_0000;
      hist_hit_r <= 1'b0;
    end else begin
      hist_hit_r <= reg_rd && hist_hit;
      rdata_r    <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          OFS_CTRL:     rdata_r <= {29'h0, ctype_r, en_r};
          OFS_NORM:     rdata_r <= {8'h00, norm_r};
          OFS_THRESH:   rdata_r <= {24'h0, thresh_r};
          OFS_SMOOTH:   rdata_r <= {28'h0, smooth_r};
          OFS_AVG:      rdata_r <= {14'h0, mon_r, avg_r};
          OFS_WPTR:     rdata_r <= {22'h0, wptr_r};
          OFS_IRQ_STAT: rdata_r <= {29'h0, stat_r};
          OFS_IRQ_MASK: rdata_r <= {29'h0, mask_r};
          OFS_LAST:     rdata_r <= {24'h0, last_r};
          default: begin
            // Unmapped reads return zero; history comes from memory
          end
        endcase
      end
    end
  end
  assign reg_rdata = hist_hit_r ? {24'h0, hist_q} : rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper for the one-shot check: set by an alert, cleared by arming
  logic alert_seen_r;                  // An alert went out since the last arming
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_seen_r <= 1'b0;
    end else if (arm_wr) begin
      alert_seen_r <= 1'b0;
    end else if (alert_pulse) begin
      alert_seen_r <= 1'b1;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick [*2]) else $error("sample ticks too close");
  a_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    wrap |=> (wptr_r == '0)) else $error("pointer did not wrap");
  a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && en_r && !wrap) |=> (wptr_r == $past(wptr_r) + 1'b1)) else $error("pointer did not advance");
  a_one_alert: assert property (@(posedge clk) disable iff (!rst_n)
    alert_seen_r |-> !alert_pulse) else $error("second alert without rearm");
  a_arm_clear: assert property (@(posedge clk) disable iff (!rst_n)
    arm_wr |=> (avg_r == 16'h0000) && (mon_r == OBOM_PRIME)) else $error("arming left state");
  a_avg_direct: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !arm_wr && (mon_r != OBOM_IDLE) && (smooth_r == 4'h0)) |=> (avg_r == {$past(cur_code), 8'h00}))
    else $error("average with alpha one not equal to sample");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (mon_r == OBOM_IDLE) |-> !alert_pulse) else $error("alert while unarmed");
  a_last_sample: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && en_r) |=> (last_r == $past(cur_code))) else $error("sample not stored");
  a_stat_set: assert property (@(posedge clk) disable iff (!rst_n)
    (|ev) |=> ((stat_r & $past(ev)) == $past(ev))) else $error("event lost from status");

  c_alert:   cover property (@(posedge clk) disable iff (!rst_n) alert_pulse);
  c_wrap:    cover property (@(posedge clk) disable iff (!rst_n) wrap);
  c_rearm:   cover property (@(posedge clk) disable iff (!rst_n) (mon_r == OBOM_FIRED) ##1 arm_wr);
  c_hist_rd: cover property (@(posedge clk) disable iff (!rst_n) (reg_rd && hist_hit && tick));
endmodule : obom_monitor

//--- bench/obom_core_model.sv
// Head-end core model: drives the register port of the monitor.
// Assumes one system clock; every strobe changes just after a rising edge.
`timescale 1ns/10ps
module obom_core_model
  import obom_pkg::*;
(
  input  wire logic        clk,        // System clock
  output logic      [11:0] reg_addr,   // Register byte address
  output logic      [31:0] reg_wdata,  // Write data
  output logic             reg_wr,     // Write strobe
  output logic             reg_rd      // Read strobe
);
  logic [7:0] thr_r;                   // Last threshold sent, kept for re-arming

  // Output shaping that the core keeps toward the channel
  localparam int unsigned DERATE_PM    = 990;   // Default aggregate cap, per mille
  localparam int unsigned DERATE_MIN   = 900;   // Lowest allowed cap, per mille
  localparam int unsigned STEP_PM      = 5;     // Half a percent per alert step
  localparam int unsigned BURST_US     = 1500;  // Burst limit at the network side
  localparam int unsigned LEAD_US      = 1000;  // Video lead or lag bound
  localparam int unsigned FRAME_B      = 1522;  // Largest frame in bytes
  localparam int unsigned BURST_FRAMES = 3;     // Default burst in frames per session
  int unsigned rate_pm = DERATE_PM;             // Peak rate of the whole aggregate, nulls included

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial begin
    reg_addr  = 12'h000;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    thr_r     = 8'hff;
  end

  // One-cycle write; data inverted afterwards so no stale value lingers
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read; the bench collects the data a cycle later
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd

  // Factor is the channel's maximum byte depth over 256
  task automatic norm(input int unsigned maxd);
    wr(OFS_NORM, 32'(maxd / 256));
  endtask : norm

  // Each arming remembers the threshold, a re-arm resends it
  task automatic arm(input logic [7:0] t);
    thr_r = t;
    wr(OFS_THRESH, {24'h0, t});
  endtask : arm

  task automatic rearm();
    wr(OFS_THRESH, {24'h0, thr_r});
  endtask : rearm

  // Each alert lowers the aggregate rate by half a percent, never below the floor
  task automatic slow_down();
    rate_pm = (rate_pm >= DERATE_MIN + STEP_PM) ? rate_pm - STEP_PM : DERATE_MIN;
  endtask : slow_down

  // Largest burst in bytes that the core lets out toward one channel
  function automatic int unsigned burst_cap(input int unsigned kbps, input logic video);
    int unsigned lim;
    lim = ((kbps * rate_pm) / 1000) * (video ? LEAD_US : BURST_US) / 8000;
    return (lim < BURST_FRAMES * FRAME_B) ? lim : BURST_FRAMES * FRAME_B;
  endfunction : burst_cap
endmodule : obom_core_model

//--- bench/tb_obom_monitor.sv
// Self-checking bench for the occupancy monitor with a core model on its register port.
// Assumes a short tick of 20 cycles; reads are checked against a queue of notes.
`timescale 1ns/10ps
module tb_obom_monitor;
  import obom_pkg::*;
  localparam int unsigned TICK = 20;    // Shortened sample period
  localparam int unsigned CH_KBPS = 38800; // Channel payload rate the core shapes to
  typedef struct packed {
    logic [31:0] v;                     // Expected value
    logic [31:0] m;                     // Bits compared, zero means no check
  } obom_exp_type;
  localparam logic [11:0] RA [8] = '{OFS_CTRL, OFS_NORM, OFS_THRESH, OFS_SMOOTH,
    OFS_AVG, OFS_IRQ_STAT, OFS_IRQ_MASK, 12'h024};
  localparam logic [31:0] RV [8] = '{32'h0, 32'h1, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic        clk, rst_n, alert, irq;
  logic        rd_d = 1'b0;             // Read strobe one cycle late
  logic [79:0] qd;                      // Four queue depths
  logic [11:0] addr;
  logic [31:0] wdata, rdata, seen_r;
  logic        wr, rd;
  obom_exp_type exp_q[$];
  obom_exp_type e_r;
  int error_cnt, samples_checked, alert_cnt, cyc, md, sum, d, code, p;
  integer seed = 32'h3bfe;

  obom_core_model i_core (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  obom_monitor #(.TICK_CYC(TICK)) i_obom_monitor (.clk(clk), .rst_n(rst_n), .queue_depth(qd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .alert_pulse(alert), .irq(irq));

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // Issue a read and note what it must return
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
    i_core.rd(a);
    exp_q.push_back('{v, m});
  endtask : chk_rd

  // Bounded wait for the one-cycle alert
  task automatic wait_alert();
    for (int i = 0; i < 4 * TICK; i++) begin
      @(posedge clk);
      if (alert === 1'b1) break;
    end
    check("alert_pulse", {31'h0, alert}, 32'h1);
    i_core.slow_down();
  endtask : wait_alert

  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (alert === 1'b1) alert_cnt++;
    if (rd_d === 1'b1) begin
      e_r = exp_q.pop_front();
      seen_r = rdata;
      if (e_r.m !== 32'h0) check("reg_rdata", rdata & e_r.m, e_r.v & e_r.m);
    end
  end

  // Hang guard, about half again above the expected run length of some 20500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    qd    = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) chk_rd(RA[i], RV[i], 32'hffffffff);
    $display("test reset done");
    // Random depths and factors, each channel family in turn
    for (int i = 0; i < 4; i++) begin
      md = 256 + ($unsigned($random(seed)) % 76800);
      i_core.norm(md);
      i_core.wr(OFS_CTRL, 32'(1 | ((i % 3) << 1)));
      chk_rd(OFS_CTRL, 32'(1 | ((i % 3) << 1)), 32'hffffffff);
      sum = 0;
      for (int q = 0; q < 4; q++) begin
        d = $unsigned($random(seed)) % (i_core.burst_cap(CH_KBPS, (i % 3) == 1) + 1);
        qd[q*20 +: 20] <= d[19:0];
        sum += d;
      end
      code = sum / (md / 256);
      if (code > 255) code = 255;
      repeat (2 * TICK + 5) @(posedge clk);
      chk_rd(OFS_LAST, 32'(code), 32'hff);
      chk_rd(OFS_WPTR, 32'h0, 32'hfffffc00);
      repeat (3) @(posedge clk);
      p = (seen_r[9:0] == 0) ? 999 : seen_r[9:0] - 1;
      chk_rd(OFS_HIST + 12'(p * 4), 32'(code), 32'hff);
    end
    i_core.wr(OFS_CTRL, 32'h7);
    chk_rd(OFS_CTRL, 32'h1, 32'hffffffff);
    $display("test sampling done");
    // One alert per arming, re-arm clears the average
    i_core.norm(256);
    qd <= 80'h40;
    i_core.wr(OFS_SMOOTH, 32'h0);
    repeat (TICK + 2) @(posedge clk);
    alert_cnt = 0;
    i_core.arm(8'h10);
    wait_alert();
    i_core.rearm();
    chk_rd(OFS_AVG, 32'h10000, 32'hffffffff);
    repeat (3 * TICK) @(posedge clk);
    check("alert count", 32'(alert_cnt), 32'h2);
    chk_rd(OFS_AVG, 32'h24000, 32'hffffffff);
    i_core.wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    i_core.wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test alert done");
    // Smoothing with N of one, and the clamp on N, on a narrowband channel
    i_core.wr(OFS_CTRL, 32'h5);
    chk_rd(OFS_CTRL, 32'h5, 32'hffffffff);
    i_core.wr(OFS_SMOOTH, 32'hf);
    chk_rd(OFS_SMOOTH, 32'h8, 32'hffffffff);
    i_core.wr(OFS_SMOOTH, 32'h1);
    qd <= 80'h80;
    repeat (TICK + 2) @(posedge clk);
    i_core.arm(8'h10);
    wait_alert();
    chk_rd(OFS_AVG, 32'h4000, 32'hffff);
    repeat (TICK - 2) @(posedge clk);
    chk_rd(OFS_AVG, 32'h6000, 32'hffff);
    $display("test smoothing done");
    // Pointer wrap after a thousand samples
    repeat (1000 * TICK) @(posedge clk);
    chk_rd(OFS_IRQ_STAT, 32'h4, 32'h4);
    i_core.wr(OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    i_core.wr(OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test wrap done");
    test_done();
  end
endmodule : tb_obom_monitor
